// ### csp_host_model.sv
// Host serial port model: frames words into the port and checks the words framed out of it.
`timescale 1ns/1ps
module csp_host_model (
    input  wire logic        clk,
    input  wire logic        bit_clk,
    input  wire logic        serial_data_out,
    input  wire logic        serial_data_out_oe,
    input  wire logic        out_frame_sync,
    input  wire logic        jam,
    input  wire logic [15:0] send_word,
    input  wire logic        send_go,
    output logic             send_busy,
    output logic             in_frame_sync,
    output logic             serial_data_in,
    output logic [15:0]      got_word,
    output logic             got_tgl,
    output logic             viol
);
    logic [4:0]  tx_n = 5'h00;
    logic [15:0] tx_sh = 16'h0000;
    logic        h_fs = 1'b0;
    logic        h_sd = 1'b0;
    logic        j_q = 1'b0;
    logic [4:0]  rx_n = 5'h00;

    // A jam puts a pattern that changes every clock on both inputs, which the port must ignore.
    assign in_frame_sync  = jam ? j_q : h_fs;
    assign serial_data_in = jam ? ~j_q : h_sd;
    assign send_busy      = (tx_n != 5'h00);

    // Start values of the receive side.
    initial
    begin
        got_word = 16'h0000;
        got_tgl  = 1'b0;
        viol     = 1'b0;
    end

    // The jam pattern toggles on each rising master clock edge.
    always @(posedge clk) j_q <= jam ? ~j_q : 1'b0;

    // Sync for one bit period, then sixteen bits MSB first, all launched on rising edges.
    always @(posedge bit_clk)
    begin
        if (tx_n == 5'h00 && send_go)
        begin
            h_fs  <= 1'b1;
            tx_sh <= send_word;
            tx_n  <= 5'h11;
        end
        else if (tx_n > 5'h01)
        begin
            h_fs  <= 1'b0;
            h_sd  <= tx_sh[15];
            tx_sh <= {tx_sh[14:0], 1'b0};
            tx_n  <= tx_n - 5'h01;
        end
        else if (tx_n == 5'h01)
        begin
            h_sd <= ~h_sd;
            tx_n <= 5'h00;
        end
    end

    // Sample mid-bit; the data line may only be driven, and sync only low, inside a word.
    always @(negedge bit_clk)
    begin
        if (rx_n != 5'h00)
        begin
            if (!serial_data_out_oe || out_frame_sync) viol <= 1'b1;
            got_word <= {got_word[14:0], serial_data_out};
            rx_n     <= rx_n - 5'h01;
            if (rx_n == 5'h01) got_tgl <= ~got_tgl;
        end
        else
        begin
            if (serial_data_out_oe) viol <= 1'b1;
            if (out_frame_sync === 1'b1) rx_n <= 5'h10;
        end
    end
endmodule // csp_host_model

// ### csp_params.svh
// Constants for the converter serial port: word length, divider widths and limits.
`ifndef CSP_PARAMS_SVH
`define CSP_PARAMS_SVH

// Bits in one framed serial word.
`define CSP_WORD_BITS 16
// Width of the bit counter inside a word.
`define CSP_CNT_W 4
// Last bit index of a word, at the bit counter width.
`define CSP_CNT_LAST 4'hF
// Width of each rate divider select input.
`define CSP_DIV_W 3
// Width of the divider product and the bit clock phase counter.
`define CSP_PHASE_W 7
// Smallest whole divide ratio that still gives a high and a low phase.
`define CSP_MIN_DIV 7'h02

`endif

// ### csp_pkg.sv
// Types shared by the converter serial port design.
package csp_pkg;

    // Transmit sequencer states.
    typedef enum logic [1:0] {
        CSP_TX_IDLE  = 2'b00,
        CSP_TX_SYNC  = 2'b01,
        CSP_TX_SHIFT = 2'b10
    } csp_tx_state_t;

    // Receive sequencer states.
    typedef enum logic [0:0] {
        CSP_RX_IDLE  = 1'b0,
        CSP_RX_SHIFT = 1'b1
    } csp_rx_state_t;

endpackage

// ### csp_serial_port.sv
// Converter serial port: bit clock divider, framed transmitter, framed receiver, word buffers.
`timescale 1ns/1ps
`include "csp_params.svh"

// Two-entry buffer whose outputs all come from flip-flops.
module csp_skid #(
    parameter int W = `CSP_WORD_BITS
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] in_data,
    input  wire logic         in_valid,
    output logic              in_ready,
    output logic [W-1:0]      out_data,
    output logic              out_valid,
    input  wire logic         out_ready
);
    logic [W-1:0] head_d, head_q, spare_d, spare_q;
    logic         head_v_d, head_v_q, spare_free_d, spare_free_q;
    logic         push, pop;

    // The head feeds the reader; the spare entry absorbs a word while the reader stalls.
    always_comb
    begin
        push         = in_valid & spare_free_q;
        pop          = head_v_q & out_ready;
        head_d       = head_q;
        head_v_d     = head_v_q;
        spare_d      = spare_q;
        spare_free_d = spare_free_q;
        if (pop)
        begin
            if (!spare_free_q)
            begin
                head_d       = spare_q;
                spare_free_d = 1'b1;
            end
            else if (push)
            begin
                head_d = in_data;
            end
            else
            begin
                head_v_d = 1'b0;
            end
        end
        else if (push)
        begin
            if (!head_v_q)
            begin
                head_d   = in_data;
                head_v_d = 1'b1;
            end
            else
            begin
                spare_d      = in_data;
                spare_free_d = 1'b0;
            end
        end
    end

    // Buffer registers.
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            head_q       <= '0;
            head_v_q     <= 1'b0;
            spare_q      <= '0;
            spare_free_q <= 1'b1;
        end
        else
        begin
            head_q       <= head_d;
            head_v_q     <= head_v_d;
            spare_q      <= spare_d;
            spare_free_q <= spare_free_d;
        end
    end

    assign in_ready  = spare_free_q;
    assign out_data  = head_q;
    assign out_valid = head_v_q;
endmodule // csp_skid

// Top of the serial port; clk is the externally supplied master clock.
module csp_serial_port (
    input  wire logic                        clk,
    input  wire logic                        rst_n,
    input  wire logic                        port_enable,
    input  wire logic [`CSP_DIV_W-1:0]       mclk_div_sel,
    input  wire logic [`CSP_DIV_W-1:0]       sclk_div_sel,
    output logic                             bit_clk,
    output logic                             serial_data_out,
    output logic                             serial_data_out_oe,
    output logic                             out_frame_sync,
    output logic                             out_frame_sync_oe,
    input  wire logic                        in_frame_sync,
    input  wire logic                        serial_data_in,
    input  wire logic [`CSP_WORD_BITS-1:0]   tx_data,
    input  wire logic                        tx_valid,
    output logic                             tx_ready,
    output logic [`CSP_WORD_BITS-1:0]        rx_data,
    output logic                             rx_valid,
    input  wire logic                        rx_ready,
    output logic                             rx_overrun
);
    import csp_pkg::*;

    logic [`CSP_PHASE_W-1:0]   ratio, phase_d, phase_q;
    logic [3:0]                mdiv1, sdiv1;
    logic                      rise_en, fall_en, bclk_d, bclk_q;
    csp_tx_state_t             tx_state_d, tx_state_q;
    logic [`CSP_WORD_BITS-1:0] tx_sh_d, tx_sh_q, tx_head;
    logic [`CSP_CNT_W-1:0]     tx_cnt_d, tx_cnt_q;
    logic                      sdo_d, sdo_q, sdo_oe_d, sdo_oe_q;
    logic                      ofs_d, ofs_q, ofs_oe_d, ofs_oe_q;
    logic                      tx_head_v, tx_take;
    csp_rx_state_t             rx_state_d, rx_state_q;
    logic [`CSP_WORD_BITS-1:0] rx_sh_d, rx_sh_q, rx_word;
    logic [`CSP_CNT_W-1:0]     rx_cnt_d, rx_cnt_q;
    logic                      rx_push, rx_room, ovr_d, ovr_q;

    // Divide ratio is the product of both dividers, never below two.
    always_comb
    begin
        mdiv1 = {1'b0, mclk_div_sel} + 4'h1;
        sdiv1 = {1'b0, sclk_div_sel} + 4'h1;
        ratio = {3'h0, mdiv1} * {3'h0, sdiv1};
        if (ratio < `CSP_MIN_DIV)
            ratio = `CSP_MIN_DIV;
    end

    // Phase counter; rising and falling edges are one-cycle enables. Disable parks it.
    always_comb
    begin
        rise_en = port_enable && (phase_q >= ratio - 7'h01);
        fall_en = port_enable && (phase_q == (ratio >> 1) - 7'h01);
        phase_d = rise_en ? 7'h00 : phase_q + 7'h01;
        bclk_d  = bclk_q;
        if (rise_en)
            bclk_d = 1'b1;
        else if (fall_en)
            bclk_d = 1'b0;
        if (!port_enable)
        begin
            phase_d = 7'h00;
            bclk_d  = 1'b0;
        end
    end

    // Bit clock registers.
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            phase_q <= 7'h00;
            bclk_q  <= 1'b0;
        end
        else
        begin
            phase_q <= phase_d;
            bclk_q  <= bclk_d;
        end
    end

    // Words waiting to go out; tx_ready reflects back-pressure from the serial side.
    csp_skid #(.W(`CSP_WORD_BITS)) u_tx_buf (
        .clk       (clk),
        .rst_n     (rst_n),
        .in_data   (tx_data),
        .in_valid  (tx_valid),
        .in_ready  (tx_ready),
        .out_data  (tx_head),
        .out_valid (tx_head_v),
        .out_ready (tx_take)
    );

    // Transmitter: sync bit, then sixteen data bits MSB first, all on rising edges.
    always_comb
    begin
        tx_state_d = tx_state_q;
        tx_sh_d    = tx_sh_q;
        tx_cnt_d   = tx_cnt_q;
        sdo_d      = sdo_q;
        sdo_oe_d   = sdo_oe_q;
        ofs_d      = ofs_q;
        ofs_oe_d   = port_enable;
        tx_take    = 1'b0;
        if (rise_en)
        begin
            case (tx_state_q)
                CSP_TX_SYNC:
                begin
                    ofs_d      = 1'b0;
                    sdo_d      = tx_sh_q[`CSP_WORD_BITS-1];
                    sdo_oe_d   = 1'b1;
                    tx_sh_d    = {tx_sh_q[`CSP_WORD_BITS-2:0], 1'b0};
                    tx_cnt_d   = `CSP_CNT_LAST;
                    tx_state_d = CSP_TX_SHIFT;
                end
                CSP_TX_SHIFT:
                begin
                    if (tx_cnt_q != '0)
                    begin
                        sdo_d    = tx_sh_q[`CSP_WORD_BITS-1];
                        tx_sh_d  = {tx_sh_q[`CSP_WORD_BITS-2:0], 1'b0};
                        tx_cnt_d = tx_cnt_q - 4'h1;
                    end
                    else
                    begin
                        sdo_oe_d   = 1'b0;
                        tx_state_d = CSP_TX_IDLE;
                    end
                end
                default:
                begin
                    tx_state_d = CSP_TX_IDLE;
                end
            endcase
            // A waiting word starts with its sync bit, even right after a last bit.
            if (tx_head_v && (tx_state_d == CSP_TX_IDLE))
            begin
                ofs_d      = 1'b1;
                tx_sh_d    = tx_head;
                tx_take    = 1'b1;
                tx_state_d = CSP_TX_SYNC;
            end
        end
        if (!port_enable)
        begin
            tx_state_d = CSP_TX_IDLE;
            tx_cnt_d   = '0;
            sdo_oe_d   = 1'b0;
            ofs_d      = 1'b0;
            tx_take    = 1'b0;
        end
    end

    // Transmitter registers.
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            tx_state_q <= CSP_TX_IDLE;
            tx_sh_q    <= '0;
            tx_cnt_q   <= '0;
            sdo_q      <= 1'b0;
            sdo_oe_q   <= 1'b0;
            ofs_q      <= 1'b0;
            ofs_oe_q   <= 1'b0;
        end
        else
        begin
            tx_state_q <= tx_state_d;
            tx_sh_q    <= tx_sh_d;
            tx_cnt_q   <= tx_cnt_d;
            sdo_q      <= sdo_d;
            sdo_oe_q   <= sdo_oe_d;
            ofs_q      <= ofs_d;
            ofs_oe_q   <= ofs_oe_d;
        end
    end

    // Receiver: sync seen on a falling edge, then sixteen bits taken on falling edges.
    always_comb
    begin
        rx_state_d = rx_state_q;
        rx_sh_d    = rx_sh_q;
        rx_cnt_d   = rx_cnt_q;
        rx_push    = 1'b0;
        rx_word    = {rx_sh_q[`CSP_WORD_BITS-2:0], serial_data_in};
        if (fall_en)
        begin
            case (rx_state_q)
                CSP_RX_SHIFT:
                begin
                    rx_sh_d  = rx_word;
                    rx_cnt_d = rx_cnt_q + 4'h1;
                    if (rx_cnt_q == `CSP_CNT_LAST)
                    begin
                        rx_push    = 1'b1;
                        rx_cnt_d   = '0;
                        rx_state_d = in_frame_sync ? CSP_RX_SHIFT : CSP_RX_IDLE;
                    end
                end
                default:
                begin
                    rx_cnt_d = '0;
                    if (in_frame_sync)
                        rx_state_d = CSP_RX_SHIFT;
                end
            endcase
        end
        if (!port_enable)
        begin
            rx_state_d = CSP_RX_IDLE;
            rx_cnt_d   = '0;
        end
        ovr_d = rx_push & ~rx_room;
    end

    // Receiver registers.
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rx_state_q <= CSP_RX_IDLE;
            rx_sh_q    <= '0;
            rx_cnt_q   <= '0;
            ovr_q      <= 1'b0;
        end
        else
        begin
            rx_state_q <= rx_state_d;
            rx_sh_q    <= rx_sh_d;
            rx_cnt_q   <= rx_cnt_d;
            ovr_q      <= ovr_d;
        end
    end

    // Received words; the serial side cannot stall, so a full buffer reports overrun.
    csp_skid #(.W(`CSP_WORD_BITS)) u_rx_buf (
        .clk       (clk),
        .rst_n     (rst_n),
        .in_data   (rx_word),
        .in_valid  (rx_push),
        .in_ready  (rx_room),
        .out_data  (rx_data),
        .out_valid (rx_valid),
        .out_ready (rx_ready)
    );

    // Pin outputs straight from their registers.
    assign bit_clk            = bclk_q;
    assign serial_data_out    = sdo_q;
    assign serial_data_out_oe = sdo_oe_q;
    assign out_frame_sync     = ofs_q;
    assign out_frame_sync_oe  = ofs_oe_q;
    assign rx_overrun         = ovr_q;

    // Checks on the port timing.
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence s_sync_bit;
        out_frame_sync && rise_en;
    endsequence
    sequence s_first_bit;
        !out_frame_sync && serial_data_out_oe;
    endsequence

    chk_reset_quiet: assert property ($rose(rst_n) |-> !serial_data_out_oe && !bit_clk)
        else $error("Port outputs active right after reset.");
    chk_bclk_rise: assert property (rise_en |=> bit_clk && phase_q == 7'h00)
        else $error("Bit clock did not rise with its phase restart.");
    chk_bclk_period: assert property (rise_en && $stable(ratio) |-> phase_q == ratio - 7'h01)
        else $error("Bit clock period differs from divider product.");
    chk_sdo_on_rise: assert property ($changed(serial_data_out) |-> $past(rise_en))
        else $error("Serial data changed away from a rising edge.");
    chk_sdo_float: assert property (!port_enable |=> !serial_data_out_oe && !out_frame_sync_oe)
        else $error("Port drove pins while disabled.");
    chk_sync_then_msb: assert property (s_sync_bit |=> s_first_bit)
        else $error("Frame sync not followed by the first data bit.");
    chk_fs_on_rise: assert property ($changed(out_frame_sync) |-> $past(rise_en || !port_enable))
        else $error("Frame sync changed away from a rising edge.");
    chk_rx_ignore: assert property (!port_enable |-> !rx_push && rx_state_d == CSP_RX_IDLE)
        else $error("Receiver acted while port disabled.");
    chk_rx_word_len: assert property (rx_push |-> fall_en && rx_cnt_q == `CSP_CNT_LAST)
        else $error("Received word not sixteen falling edges long.");
    chk_bclk_stop: assert property (!port_enable [*2] |-> !bit_clk && phase_q == 7'h00)
        else $error("Bit clock kept running while port disabled.");
endmodule // csp_serial_port

// ### csp_serial_port_tb_top.sv
// Testbench for the converter serial port with a host model on its serial side.
`timescale 1ns/1ps
`include "csp_params.svh"
module csp_serial_port_tb_top;
    logic        clk;
    logic        rst_n;
    logic        port_enable;
    logic [2:0]  mclk_div_sel;
    logic [2:0]  sclk_div_sel;
    logic        bit_clk;
    logic        serial_data_out;
    logic        serial_data_out_oe;
    logic        out_frame_sync;
    logic        out_frame_sync_oe;
    logic        in_frame_sync;
    logic        serial_data_in;
    logic [15:0] tx_data;
    logic        tx_valid;
    logic        tx_ready;
    logic [15:0] rx_data;
    logic        rx_valid;
    logic        rx_ready;
    logic        rx_overrun;
    logic        jam;
    logic [15:0] send_word;
    logic        send_go;
    logic        send_busy;
    logic [15:0] got_word;
    logic        got_tgl;
    logic        viol;
    logic [15:0] lfsr_q;
    logic [15:0] txq[$];
    logic [15:0] rxq[$];
    int          err_count = 0;
    int          n_compared = 0;
    int          cyc = 0;
    int          ovr_n = 0;

    csp_serial_port dut_u (.clk, .rst_n, .port_enable, .mclk_div_sel, .sclk_div_sel, .bit_clk,
        .serial_data_out, .serial_data_out_oe, .out_frame_sync, .out_frame_sync_oe,
        .in_frame_sync, .serial_data_in, .tx_data, .tx_valid, .tx_ready, .rx_data,
        .rx_valid, .rx_ready, .rx_overrun);

    csp_host_model host_u (.clk, .bit_clk, .serial_data_out, .serial_data_out_oe,
        .out_frame_sync, .jam, .send_word, .send_go, .send_busy, .in_frame_sync,
        .serial_data_in, .got_word, .got_tgl, .viol);

    // Next pseudo-random word.
    function automatic logic [15:0] rnd();
        lfsr_q = {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
        return lfsr_q;
    endfunction

    task automatic cmp_word(input string nm, input logic [15:0] e, input logic [15:0] g);
        n_compared++;
        if (g !== e)
        begin
            err_count++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic cmp_bit(input string nm, input logic e, input logic g);
        cmp_word(nm, {15'h0000, e}, {15'h0000, g});
    endtask

    task automatic conclude();
        if (err_count == 0 && n_compared > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // Valid stays high across a burst; the caller lowers it afterwards.
    task automatic tx_push(input logic [15:0] w);
        tx_data  <= w;
        tx_valid <= 1'b1;
        do @(posedge clk); while (tx_ready !== 1'b1);
        txq.push_back(w);
    endtask

    // The host frames one word; a word that the port must drop is not noted.
    task automatic host_send(input logic [15:0] w, input logic keep);
        send_word <= w;
        send_go   <= 1'b1;
        do @(posedge clk); while (send_busy !== 1'b1);
        send_go <= 1'b0;
        if (keep) rxq.push_back(w);
        do @(posedge clk); while (send_busy !== 1'b0);
    endtask

    // Period of the bit clock in master clocks against the product of both dividers.
    task automatic measure(input logic [2:0] m, input logic [2:0] s, input logic [15:0] n);
        time t0;
        mclk_div_sel <= m;
        sclk_div_sel <= s;
        repeat (3) @(posedge bit_clk);
        t0 = $time;
        @(posedge bit_clk);
        cmp_word("bit_clk_period", n, 16'(($time - t0) / 5));
    endtask

    // Clock generator; it stands in for the external master clock source.
    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // Words framed out by the port are checked against the oldest transmit note.
    initial
    begin
        wait (rst_n === 1'b1);
        forever
        begin
            @(got_tgl);
            if (txq.size() == 0) cmp_word("tx_extra", 16'h0000, 16'hFFFF);
            else cmp_word("tx_word", txq.pop_front(), got_word);
        end
    end

    // Received words, overrun pulses and the run limit.
    always @(posedge clk)
    begin
        cyc++;
        if (rst_n && rx_valid === 1'b1 && rx_ready === 1'b1)
        begin
            if (rxq.size() == 0) cmp_word("rx_extra", 16'h0000, 16'hFFFF);
            else cmp_word("rx_word", rxq.pop_front(), rx_data);
        end
        if (rx_overrun === 1'b1) ovr_n++;
        if (cyc == 20000)
        begin
            err_count++;
            conclude();
        end
    end

    // Main sequence.
    initial
    begin
        lfsr_q = 16'h0063;
        rst_n = 1'b0;
        port_enable = 1'b0;
        mclk_div_sel = 3'h0;
        sclk_div_sel = 3'h0;
        tx_data = 16'h0000;
        tx_valid = 1'b0;
        rx_ready = 1'b1;
        jam = 1'b0;
        send_word = 16'h0000;
        send_go = 1'b0;
        repeat (3) @(posedge clk);
        cmp_bit("bit_clk", 1'b0, bit_clk);
        cmp_bit("tx_ready", 1'b1, tx_ready);
        cmp_bit("rx_valid", 1'b0, rx_valid);
        @(posedge clk);
        rst_n <= 1'b1;
        port_enable <= 1'b1;
        measure(3'h0, 3'h0, 16'h0002);
        measure(3'h1, 3'h2, 16'h0006);
        measure(3'h3, 3'h1, 16'h0008);
        measure(3'h7, 3'h7, 16'h0040);
        measure(3'h1, 3'h1, 16'h0004);
        port_enable <= 1'b0;
        repeat (3) @(posedge clk);
        cmp_bit("sdo_oe", 1'b0, serial_data_out_oe);
        cmp_bit("fs_oe", 1'b0, out_frame_sync_oe);
        cmp_bit("bit_clk", 1'b0, bit_clk);
        tx_push(rnd());
        tx_push(rnd());
        tx_data <= rnd();
        jam <= 1'b1;
        repeat (4) @(posedge clk);
        cmp_bit("tx_ready", 1'b0, tx_ready);
        repeat (36) @(posedge clk);
        tx_valid <= 1'b0;
        jam <= 1'b0;
        @(posedge clk);
        port_enable <= 1'b1;
        fork
            begin
                repeat (4) tx_push(rnd());
                tx_valid <= 1'b0;
            end
            repeat (3) host_send(rnd(), 1'b1);
        join
        rx_ready <= 1'b0;
        host_send(rnd(), 1'b1);
        host_send(rnd(), 1'b1);
        host_send(rnd(), 1'b0);
        repeat (8) @(posedge clk);
        cmp_word("overruns", 16'h0001, 16'(ovr_n));
        rx_ready <= 1'b1;
        repeat (4000) @(posedge clk) if (txq.size() == 0 && rxq.size() == 0) break;
        cmp_word("tx_left", 16'h0000, 16'(txq.size()));
        cmp_word("rx_left", 16'h0000, 16'(rxq.size()));
        cmp_bit("framing", 1'b0, viol);
        conclude();
    end
endmodule // csp_serial_port_tb_top
